// ---- logic/lpm_wakeup_clock_mask.sv ----
// Purpose: Wake-up clock mask and supervisor settling sequencer
// Assumes: wake and core_ok are synchronous to clk
// Notes: Slow counts are parameters so a bench can shorten them
//
// Behaviour
// - Oscillator overshoot window lasts 6 us.
// - Normal supervisor mode holds CPU 150 us.
// - Fast mode mask 2 us; flag exposed clock.
// - Subsystem clock gets no wake-up mask.
// - Full-performance settling delay about 2 us.
// - Unsettled raised core level issues reset.
// - Normal-mode settling delay about 150 us.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module lpm_wakeup_clock_mask #(
    parameter int unsigned MASK_SLOW_CYC = lpm_pkg::MASK_SLOW_CYC,
    parameter int unsigned SETTLE_SLOW_CYC = lpm_pkg::SETTLE_SLOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power events
    input wire logic wake,
    input wire logic core_ok,
    // Clock and CPU control
    output logic cpu_hold,
    output logic main_clock_en,
    output logic subsystem_clock_en,
    output logic [2:0] main_clock_divider,
    output logic osc_overshoot,
    output logic [1:0] core_level,
    output logic pmm_reset
);
    localparam int TW = lpm_pkg::TIMER_W;
    localparam int MASK_FAST = lpm_pkg::MASK_FAST_CYC;
    localparam int SETTLE_FAST = lpm_pkg::SETTLE_FAST_CYC;
    localparam int FAST_TAIL = lpm_pkg::MASK_FAST_CYC - 7;
    localparam int OVER_TAIL = lpm_pkg::OVERSHOOT_CYC - 7;

    if (MASK_SLOW_CYC == 0 || MASK_SLOW_CYC >= (1 << TW) ||
        SETTLE_SLOW_CYC == 0 || SETTLE_SLOW_CYC >= (1 << TW)) begin : g_bad
        $error("slow counts must fit the timer width and be nonzero");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] level_limit(input logic [1:0] lvl);
        return (lvl == 2'h0) ? lpm_pkg::LIM_L0 : (lvl == 2'h1) ? lpm_pkg::LIM_L1 :
               (lvl == 2'h2) ? lpm_pkg::LIM_L2 : lpm_pkg::LIM_L3;
    endfunction

    reg_access_if ra ();

    axil_slave u_bus (
        .clk(clk),
        .rst(rst),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .ra(ra.slave)
    );

    lpm_pkg::pwr_state_t state_q, state_d;
    logic [5:0] ctrl_q, clkf_q;
    logic [15:0] khz_q;
    logic [1:0] level_q;
    logic fast_q, exposed_q, deep_q;
    logic hold_q, main_en_q, sub_en_q, over_q, reset_q;
    logic mask_busy, mask_done, osc_busy, osc_done, set_busy, set_done;
    logic [TW-1:0] mask_cnt, set_cnt;

    // Register write decode
    wire wr_ctrl = ra.wr_stb && ra.wr_addr == lpm_pkg::CTRL_OFS;
    wire wr_clk = ra.wr_stb && ra.wr_addr == lpm_pkg::CLK_OFS;
    wire wr_lpm = ra.wr_stb && ra.wr_addr == lpm_pkg::LPM_OFS;
    wire wr_stat = ra.wr_stb && ra.wr_addr == lpm_pkg::STAT_OFS;
    assign ra.wr_hit = ra.wr_addr inside {lpm_pkg::CTRL_OFS, lpm_pkg::CLK_OFS,
                                          lpm_pkg::LPM_OFS, lpm_pkg::STAT_OFS};
    wire [31:0] ctrl_word = {26'h0, ctrl_q};
    wire [31:0] clk_word = {khz_q, 10'h0, clkf_q};
    wire [31:0] ctrl_new = merge(ctrl_word, ra.wr_data, ra.wr_strb);
    wire [31:0] clk_new = merge(clk_word, ra.wr_data, ra.wr_strb);
    wire [1:0] level_new = ctrl_new[lpm_pkg::LEVEL_LSB +: 2];
    wire enter = wr_lpm && ra.wr_strb[0] && ra.wr_data[lpm_pkg::ENTER_BIT];

    wire in_sleep = state_q == lpm_pkg::PWR_STATE3 || state_q == lpm_pkg::PWR_STATE4;
    wire wake_take = in_sleep && wake;
    // Fast wake-up: both low-side units off, or both in full performance
    wire fast_now = (!ctrl_q[lpm_pkg::SUP_EN_BIT] && !ctrl_q[lpm_pkg::MON_EN_BIT]) ||
                    (ctrl_q[lpm_pkg::SUP_FP_BIT] && ctrl_q[lpm_pkg::MON_FP_BIT]);
    wire [TW-1:0] mask_len = fast_now ? TW'(MASK_FAST) : TW'(MASK_SLOW_CYC);
    wire raise = wr_ctrl && level_new > level_q;
    wire [TW-1:0] settle_len = ctrl_new[lpm_pkg::SUP_FP_BIT] ?
                               TW'(lpm_pkg::SETTLE_FAST_CYC) : TW'(SETTLE_SLOW_CYC);
    wire expose = mask_done && fast_q && clkf_q[lpm_pkg::MAIN_OSC_BIT] &&
                  clkf_q[lpm_pkg::DIV_LSB +: 3] == 3'h0 && khz_q > level_limit(level_q);
    wire sleep_d = state_d == lpm_pkg::PWR_STATE3 || state_d == lpm_pkg::PWR_STATE4;

    // Register read decode
    wire [31:0] lpm_word = {30'h0, deep_q, in_sleep};
    wire [31:0] stat_word = {24'h0, level_q, exposed_q, fast_q, set_busy, over_q,
                             hold_q, in_sleep};
    assign ra.rd_hit = ra.rd_addr inside {lpm_pkg::CTRL_OFS, lpm_pkg::CLK_OFS,
                                          lpm_pkg::LPM_OFS, lpm_pkg::STAT_OFS};
    assign ra.rd_data = (ra.rd_addr == lpm_pkg::CTRL_OFS) ? ctrl_word :
                        (ra.rd_addr == lpm_pkg::CLK_OFS) ? clk_word :
                        (ra.rd_addr == lpm_pkg::LPM_OFS) ? lpm_word :
                        (ra.rd_addr == lpm_pkg::STAT_OFS) ? stat_word : 32'h0;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lpm_pkg::PWR_ACTIVE: begin
                if (enter) begin
                    state_d = ra.wr_data[lpm_pkg::DEEP_BIT] ? lpm_pkg::PWR_STATE4 :
                              lpm_pkg::PWR_STATE3;
                end
            end
            lpm_pkg::PWR_STATE3, lpm_pkg::PWR_STATE4: begin
                if (wake) begin
                    state_d = lpm_pkg::PWR_WAKE;
                end
            end
            lpm_pkg::PWR_WAKE: begin
                if (mask_done) begin
                    state_d = lpm_pkg::PWR_ACTIVE;
                end
            end
        endcase
    end

    countdown_timer #(.W(TW)) u_mask (
        .clk(clk), .rst(rst), .load(wake_take), .len(mask_len),
        .busy(mask_busy), .done(mask_done), .count(mask_cnt)
    );
    countdown_timer #(.W(TW)) u_osc (
        .clk(clk), .rst(rst), .load(wake_take), .len(TW'(lpm_pkg::OVERSHOOT_CYC)),
        .busy(osc_busy), .done(osc_done), .count()
    );
    countdown_timer #(.W(TW)) u_settle (
        .clk(clk), .rst(rst), .load(raise), .len(settle_len),
        .busy(set_busy), .done(set_done), .count(set_cnt)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= lpm_pkg::CTRL_RST;
            clkf_q <= lpm_pkg::CLKF_RST;
            khz_q <= lpm_pkg::KHZ_RST;
            level_q <= 2'h0;
            deep_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new[5:0];
                level_q <= level_new;
            end
            if (wr_clk) begin
                clkf_q <= clk_new[5:0];
                khz_q <= clk_new[lpm_pkg::KHZ_LSB +: 16];
            end
            if (enter && state_q == lpm_pkg::PWR_ACTIVE) begin
                deep_q <= ra.wr_data[lpm_pkg::DEEP_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= lpm_pkg::PWR_ACTIVE;
            fast_q <= 1'b0;
            exposed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (wake_take) begin
                fast_q <= fast_now;
            end
            // Set wins over a clear in the same cycle
            if (expose) begin
                exposed_q <= 1'b1;
            end else if (wr_stat && ra.wr_strb[0] && ra.wr_data[lpm_pkg::EXPOSED_BIT]) begin
                exposed_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b0;
            main_en_q <= 1'b1;
            sub_en_q <= 1'b1;
            over_q <= 1'b0;
            reset_q <= 1'b0;
        end else begin
            hold_q <= state_d != lpm_pkg::PWR_ACTIVE;
            main_en_q <= !sleep_d;
            sub_en_q <= !sleep_d || clkf_q[lpm_pkg::SREQ_BIT];
            over_q <= wake_take || (osc_busy && !osc_done);
            reset_q <= set_done && !raise && !core_ok;
        end
    end

    assign cpu_hold = hold_q;
    assign main_clock_en = main_en_q;
    assign subsystem_clock_en = sub_en_q;
    assign main_clock_divider = clkf_q[lpm_pkg::DIV_LSB +: 3];
    assign osc_overshoot = over_q;
    assign core_level = level_q;
    assign pmm_reset = reset_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    fast_mask_a: assert property (wake_take && fast_now |=>
        cpu_hold[*8] ##FAST_TAIL !cpu_hold)
        else $error("fast wake-up mask has the wrong length");
    slow_len_a: assert property (wake_take && !fast_now |=>
        mask_cnt == TW'(MASK_SLOW_CYC) && cpu_hold)
        else $error("slow wake-up mask not loaded");
    mask_hold_a: assert property (mask_busy && !wake_take |=> $stable(fast_q))
        else $error("mask mode changed during the mask");
    overshoot_len_a: assert property (wake_take |=>
        osc_overshoot[*8] ##OVER_TAIL !osc_overshoot)
        else $error("overshoot window has the wrong length");
    sub_unmasked_a: assert property (wake_take |=> subsystem_clock_en)
        else $error("subsystem clock held during wake-up mask");
    settle_fast_a: assert property (raise && ctrl_new[lpm_pkg::SUP_FP_BIT] |=>
        set_cnt == TW'(SETTLE_FAST))
        else $error("full-performance settling length wrong");
    settle_slow_a: assert property (raise && !ctrl_new[lpm_pkg::SUP_FP_BIT] |=>
        set_cnt == TW'(SETTLE_SLOW_CYC))
        else $error("normal settling length wrong");
    reset_cause_a: assert property (pmm_reset |-> $past(set_done && !core_ok))
        else $error("reset without failed settling");
endmodule

// ---- logic/lpm_pkg.sv ----
// Purpose: Shared constants for the low-power wake-up clock mask block
// Assumes: 40 MHz clock, AXI4-Lite register access with 8-bit addresses
// Notes: Times are kept in ns; cycle counts are derived from them
package lpm_pkg;
    localparam int CLK_NS = 25;
    // Times in ns as specified
    localparam int OVERSHOOT_NS = 6000;
    localparam int MASK_SLOW_NS = 150000;
    localparam int MASK_FAST_NS = 2000;
    localparam int SETTLE_FAST_NS = 2000;
    localparam int SETTLE_SLOW_NS = 150000;
    // Longest time rounds down, least times round up
    localparam int OVERSHOOT_CYC = OVERSHOOT_NS / CLK_NS;
    localparam int MASK_SLOW_CYC = (MASK_SLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int MASK_FAST_CYC = (MASK_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_FAST_CYC = (SETTLE_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_SLOW_CYC = (SETTLE_SLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W = 13;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CLK_OFS = 8'h04;
    localparam logic [7:0] LPM_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    // Supervision control fields
    localparam int SUP_EN_BIT = 0;
    localparam int MON_EN_BIT = 1;
    localparam int SUP_FP_BIT = 2;
    localparam int MON_FP_BIT = 3;
    localparam int LEVEL_LSB = 4;
    localparam logic [5:0] CTRL_RST = 6'h03;
    // Clock control fields
    localparam int DIV_LSB = 0;
    localparam int SREQ_BIT = 3;
    localparam int SUB_OSC_BIT = 4;
    localparam int MAIN_OSC_BIT = 5;
    localparam int KHZ_LSB = 16;
    localparam logic [5:0] CLKF_RST = 6'h38;
    localparam logic [15:0] KHZ_RST = 16'h0fa0;
    localparam logic [2:0] DIV_HALF = 3'h1;
    // Low-power entry fields
    localparam int ENTER_BIT = 0;
    localparam int DEEP_BIT = 1;
    // Status fields
    localparam int EXPOSED_BIT = 5;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Main clock limits per core level, in kHz
    localparam logic [15:0] LIM_L0 = 16'h1388;
    localparam logic [15:0] LIM_L1 = 16'h1d4c;
    localparam logic [15:0] LIM_L2 = 16'h2710;
    localparam logic [15:0] LIM_L3 = 16'h30d4;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_STATE3 = 2'b01,
        PWR_STATE4 = 2'b10,
        PWR_WAKE = 2'b11
    } pwr_state_t;
endpackage

// ---- logic/reg_access_if.sv ----
// Purpose: Register access between the bus slave and the sequencer core
// Assumes: One clock; wr_stb is a one-cycle pulse
// Notes: Decode answers (hit, read data) come back combinationally
`timescale 1ns/10ps
interface reg_access_if;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    modport slave(output wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                  input wr_hit, rd_data, rd_hit);
    modport core(input wr_stb, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface

// ---- logic/countdown_timer.sv ----
// Purpose: Loadable down-counter for mask, overshoot and settling windows
// Assumes: len is at least one
// Notes: done pulses in the last busy cycle
`timescale 1ns/10ps
module countdown_timer #(
    parameter int W = 13
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [W-1:0] len,
    // State
    output logic busy,
    output logic done,
    output logic [W-1:0] count
);
    logic [W-1:0] count_q;
    assign count = count_q;
    assign busy = count_q != '0;
    assign done = count_q == W'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= len;
        end else if (busy) begin
            count_q <= count_q - W'(1);
        end
    end

    timer_load_a: assert property (@(posedge clk) disable iff (rst)
        load |=> count == $past(len))
        else $error("timer did not take its length");
    timer_end_a: assert property (@(posedge clk) disable iff (rst)
        done && !load |=> !busy)
        else $error("timer ran past its end");
endmodule

// ---- logic/axil_slave.sv ----
// Purpose: AXI4-Lite slave front end for the sequencer registers
// Assumes: Master holds valid and payload until taken
// Notes: Address and data are taken together; one answer per access
`timescale 1ns/10ps
module axil_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Core side
    reg_access_if.slave ra
);
    logic wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    wire w_take = wready_q && awvalid && wvalid;
    wire r_take = arready_q && arvalid;
    // Ready pulses only when both halves are present, so neither is orphaned
    wire w_offer = !wready_q && awvalid && wvalid && !bvalid_q;
    wire r_offer = !arready_q && arvalid && !rvalid_q;

    assign awready = wready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;
    assign ra.wr_stb = w_take;
    assign ra.wr_addr = awaddr;
    assign ra.wr_data = wdata;
    assign ra.wr_strb = wstrb;
    assign ra.rd_addr = araddr;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= lpm_pkg::RESP_OKAY;
        end else begin
            wready_q <= w_offer;
            if (w_take) begin
                bvalid_q <= 1'b1;
                bresp_q <= ra.wr_hit ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= lpm_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else begin
            arready_q <= r_offer;
            if (r_take) begin
                rvalid_q <= 1'b1;
                rresp_q <= ra.rd_hit ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR;
                rdata_q <= ra.rd_data;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule

// ---- tb/cpu_partner.sv ----
// Purpose: Far-side model: wake source and core supply ramp
// Assumes: Ramp length set by the bench, in cycles
// Notes: core_ok drops the cycle after a level rise when ramp_cyc is nonzero
`timescale 1ns/10ps
module cpu_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic wake_req,
    input wire logic [8:0] ramp_cyc,
    // Block side
    input wire logic [1:0] core_level,
    output logic wake,
    output logic core_ok
);
    logic [1:0] level_q;
    logic [8:0] ramp_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake <= 1'b0;
            level_q <= 2'h0;
            ramp_q <= 9'h000;
        end else begin
            wake <= wake_req;
            level_q <= core_level;
            // Supply takes ramp_cyc cycles to climb; a ramp_cyc of zero is instant
            if (core_level > level_q) begin
                ramp_q <= ramp_cyc;
            end else if (ramp_q != 9'h000) begin
                ramp_q <= ramp_q - 9'h001;
            end
        end
    end
    assign core_ok = (ramp_q == 9'h000);
endmodule

// ---- tb/lpm_wakeup_clock_mask_test.sv ----
// Purpose: Self-checking bench for the wake-up clock mask block
// Assumes: Slow mask and settling counts shortened to 20 cycles
// Notes: Registers reached as an AXI4-Lite master
`timescale 1ns/10ps
module lpm_wakeup_clock_mask_test;
    localparam int SLOW = 20;
    localparam int FAST = 80;
    logic clk, rst, wake, core_ok, wake_req;
    logic [8:0] ramp_cyc;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, rd;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, core_level, lvl;
    logic cpu_hold, main_clock_en, subsystem_clock_en, osc_overshoot, pmm_reset;
    logic [2:0] main_clock_divider;
    logic [15:0] khz;
    int mismatches, comparisons, n, exp_n;

    lpm_wakeup_clock_mask #(.MASK_SLOW_CYC(SLOW), .SETTLE_SLOW_CYC(SLOW)) i_dut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake, .core_ok, .cpu_hold,
        .main_clock_en, .subsystem_clock_en, .main_clock_divider, .osc_overshoot,
        .core_level, .pmm_reset
    );
    cpu_partner i_cpu (.clk, .rst, .wake_req, .ramp_cyc, .core_level, .wake, .core_ok);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic exp_exposed(input logic [1:0] lv, input logic [15:0] k);
        logic [15:0] lim [4];
        lim = '{lpm_pkg::LIM_L0, lpm_pkg::LIM_L1, lpm_pkg::LIM_L2, lpm_pkg::LIM_L3};
        return k > lim[lv];
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge clk);
        while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge clk);
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk);
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // Wake from sleep, count masked and overshoot cycles after the wake edge
    task automatic wake_run(input int exp_hold, input logic mid, input logic sub_sleep);
        int hold, over;
        hold = 0;
        over = 0;
        @(posedge clk);
        check("cpu_hold asleep", 32'h1, cpu_hold);
        check("main clock asleep", 32'h0, main_clock_en);
        check("subsystem asleep", sub_sleep, subsystem_clock_en);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        @(posedge clk);
        fork
            begin
                @(posedge clk);
                check("main clock woken", 32'h1, main_clock_en);
                check("subsystem woken", 32'h1, subsystem_clock_en);
                hold = int'(cpu_hold === 1'b1);
                over = int'(osc_overshoot === 1'b1);
                repeat (299) begin
                    @(posedge clk);
                    hold += int'(cpu_hold === 1'b1);
                    over += int'(osc_overshoot === 1'b1);
                end
            end
            if (mid) begin
                repeat (5) @(posedge clk);
                axi_wr(lpm_pkg::CTRL_OFS, 32'h3, lpm_pkg::RESP_OKAY);
            end
        join
        check("hold cycles", exp_hold, hold);
        check("overshoot cycles", 32'hf0, over);
        $display("test wake done");
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        {wake_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        ramp_cyc = 9'h000;
        mismatches = 0;
        comparisons = 0;
        lfsr = 32'hadf1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("reset hold", 32'h1, {cpu_hold, main_clock_en, subsystem_clock_en} == 3'h3);
        axi_rd(lpm_pkg::CTRL_OFS, lpm_pkg::RESP_OKAY, rd);
        check("ctrl reset", 32'h3, rd);
        axi_rd(lpm_pkg::CLK_OFS, lpm_pkg::RESP_OKAY, rd);
        check("clk reset", 32'h0fa00038, rd);
        axi_rd(lpm_pkg::STAT_OFS, lpm_pkg::RESP_OKAY, rd);
        check("status reset", 32'h0, rd);
        axi_rd(8'h10, lpm_pkg::RESP_SLVERR, rd);
        check("unmapped read", 32'h0, rd);
        axi_wr(8'h10, 32'hffffffff, lpm_pkg::RESP_SLVERR);
        s_axi_wstrb <= 4'hc;
        axi_wr(lpm_pkg::CLK_OFS, 32'h12345600, lpm_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_rd(lpm_pkg::CLK_OFS, lpm_pkg::RESP_OKAY, rd);
        check("clk byte strobes", 32'h12340038, rd);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        repeat (3) @(posedge clk);
        check("wake while active", 32'h0, {cpu_hold, osc_overshoot});
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            lvl = lfsr[17:16];
            khz = {2'h0, lfsr[13:0]};
            axi_wr(lpm_pkg::CTRL_OFS, {26'h0, lvl, 4'hf}, lpm_pkg::RESP_OKAY);
            check("core level", {30'h0, lvl}, {30'h0, core_level});
            axi_wr(lpm_pkg::CLK_OFS, {khz, 16'h0038}, lpm_pkg::RESP_OKAY);
            axi_wr(lpm_pkg::STAT_OFS, 32'h20, lpm_pkg::RESP_OKAY);
            axi_wr(lpm_pkg::LPM_OFS, 32'h1, lpm_pkg::RESP_OKAY);
            wake_run(FAST, i == 1, 1'b1);
            axi_rd(lpm_pkg::STAT_OFS, lpm_pkg::RESP_OKAY, rd);
            // Mid-mask write drops the level to 0 before the mask ends
            check("exposed", exp_exposed((i == 1) ? 2'h0 : lvl, khz), rd[5]);
        end
        axi_wr(lpm_pkg::CTRL_OFS, 32'h3, lpm_pkg::RESP_OKAY);
        axi_wr(lpm_pkg::CLK_OFS, 32'h0fa00031, lpm_pkg::RESP_OKAY);
        axi_wr(lpm_pkg::LPM_OFS, 32'h3, lpm_pkg::RESP_OKAY);
        axi_rd(lpm_pkg::LPM_OFS, lpm_pkg::RESP_OKAY, rd);
        check("deep sleep", 32'h3, rd);
        check("divider", 32'h1, main_clock_divider);
        wake_run(SLOW, 1'b0, 1'b0);
        axi_wr(lpm_pkg::CLK_OFS, 32'h0fa00038, lpm_pkg::RESP_OKAY);
        check("divider restored", 32'h0, main_clock_divider);
        for (int i = 0; i < 3; i++) begin
            axi_wr(lpm_pkg::CTRL_OFS, 32'h3, lpm_pkg::RESP_OKAY);
            repeat (2) @(posedge clk);
            ramp_cyc <= (i == 2) ? 9'h005 : 9'h0c8;
            axi_wr(lpm_pkg::CTRL_OFS, (i == 0) ? 32'h17 : 32'h13, lpm_pkg::RESP_OKAY);
            n = 0;
            while (pmm_reset !== 1'b1 && n < 150) begin
                @(posedge clk);
                n++;
            end
            // Reset seen one window length after the write returns; pass 2's short ramp gives none, so n runs to 150
            exp_n = (i == 2) ? 32'h96 : (i == 0) ? FAST : SLOW;
            check("settle cycles", exp_n, n);
            $display("test settle done");
        end
        end_sim();
    end
endmodule
